/* logic/multiphase_protection_supervisor.sv */
// Summary of operation
// R1 - output below foldback level selects the lower foldback current level
// R2 - output at zero volts slows the oscillator to one fifth rate
// R3 - power ok released only while output voltage is inside window
// R4 - out of window keeps power ok low regardless of phase checks
// R5 - in window, three missed-current cycles on any phase pull power ok low
// R6 - above crowbar trip level all phase drives are forced low
// R7 - crowbar holds until below release level, then switching resumes
// R8 - compensation node low stops oscillator and drives all phases low
// R9 - disable is no shutdown; reference stays available throughout
// R10 - each phase switches at a quarter of oscillator rate; code only rotates over enabled phases (quarter rate with all four on)
// R11 - each oscillator cycle sets next active phase; current trip clears it
// R12 - never more than one phase drive high at a time
// R13 - comparator bits synchronised, sampled once per oscillator cycle
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mps_params.svh"
module multiphase_protection_supervisor
  import mps_pkg::*;
#(
  parameter int RAMP_W = 8
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire cmp_s        cmp_in,
  output logic      [3:0]  phase_drive,
  output logic             fold_level_sel,
  output logic             osc_running,
  output logic             ref_enable,
  output logic             power_ok_output_out,
  output logic             power_ok_output_oe,
  output logic             irq
);
  localparam int NORM_DIV = `CLK_HZ / `OSC_HZ;
  localparam int SLOW_DIV = NORM_DIV * `SLOW_FACTOR;
  localparam logic [RAMP_W-1:0] NORM_LOAD = RAMP_W'(NORM_DIV - 1);
  localparam logic [RAMP_W-1:0] SLOW_LOAD = RAMP_W'(SLOW_DIV - 1);

  function automatic logic [1:0] next_phase(input logic [1:0] cur,
                                            input logic [3:0] mask);
    logic [1:0] p, r;
    p = cur;
    r = cur;
    for (int i = 1; i <= 4; i++) begin
      p = 2'(cur + 2'(i));
      if (mask[p] && r == cur) begin
        r = p;
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] miss_step(input logic [1:0] c,
                                           input logic seen);
    return seen ? 2'd0 : (c == `MISS_LIMIT ? c : 2'(c + 2'd1));
  endfunction

  cmp_s              sync1_q, sync2_q, smp_q;
  mode_e             mode_q, mode_d;
  logic [RAMP_W-1:0] ramp_q;
  logic              cb_q;
  logic [1:0]        ptr_q;
  logic              on_valid_q;
  logic              seen_q;
  logic [1:0]        miss_q [4];
  logic              pok_q;
  logic [3:0]        drive_q;
  logic [31:0]       ctrl_q;
  logic [3:0]        irq_stat_q, irq_en_q;
  logic [31:0]       prdata_q;
  logic              pslverr_q;
  logic [3:0]        open_q;

  // level sync only; comparator edges faster than clk are not expected
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce) begin
      sync1_q <= cmp_in; // R13
      sync2_q <= sync1_q;
    end
  end

  wire logic       run_w     = (mode_q != MODE_OFF);
  wire logic       osc_tick  = ce && run_w && (ramp_q == '0);
  // while stopped, sample every clk so the crowbar flag and window sample are current when disable releases
  wire logic       samp_tick = osc_tick || (ce && !run_w);
  wire logic       sw_en     = ctrl_q[`CTRL_EN_BIT];
  wire logic [3:0] ph_mask   = ctrl_q[`CTRL_MASK_LSB +: 4];
  wire logic [1:0] nxt_ptr   = next_phase(ptr_q, ph_mask);
  wire logic       slow_w    = smp_q.at_zero;
  wire logic [RAMP_W-1:0] reload = slow_w ? SLOW_LOAD : NORM_LOAD; // R2

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ramp_q <= NORM_LOAD;
    end else if (ce && run_w) begin
      ramp_q <= (ramp_q == '0) ? reload : ramp_q - 1'b1; // R2 R10
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cb_q  <= 1'b0;
      smp_q <= '0;
    end else if (samp_tick) begin
      smp_q <= sync2_q; // R13
      if (sync2_q.above_trip) begin
        cb_q <= 1'b1; // R6
      end else if (sync2_q.below_release) begin
        cb_q <= 1'b0; // R7
      end
    end
  end

  always_comb begin
    case (1'b1)
      sync2_q.comp_low: mode_d = MODE_OFF; // R8
      cb_q:             mode_d = MODE_CROWBAR; // R6
      default:          mode_d = MODE_RUN; // R7
    endcase
  end

  wire logic go_w = osc_tick && (mode_q == MODE_RUN) && sw_en && (|ph_mask);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive_q    <= '0;
      ptr_q      <= 2'd3;
      on_valid_q <= 1'b0;
    end else if (ce) begin
      case (mode_q)
        MODE_RUN: begin
          if (go_w) begin
            ptr_q      <= nxt_ptr; // R11 R10
            drive_q    <= 4'b0001 << nxt_ptr; // R12
            on_valid_q <= 1'b1;
          end else begin
            if (osc_tick) begin
              drive_q    <= '0;
              on_valid_q <= 1'b0;
            end else if (sync2_q.cur_trip) begin
              drive_q <= '0; // R11
            end
          end
        end
        default: begin
          drive_q    <= '0; // R6 R8
          on_valid_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seen_q <= 1'b0;
    end else if (ce) begin
      if (osc_tick) begin
        seen_q <= 1'b0;
      end else if (|drive_q && sync2_q.cur_present) begin
        seen_q <= 1'b1;
      end
    end
  end

  // counts only run while in window; a window exit restarts the check
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        miss_q[i] <= '0;
      end
    end else if (ce) begin
      if (!smp_q.in_window || mode_q != MODE_RUN) begin
        for (int i = 0; i < 4; i++) begin
          miss_q[i] <= '0;
        end
      end else if (osc_tick && on_valid_q) begin
        miss_q[ptr_q] <= miss_step(miss_q[ptr_q], seen_q); // R5
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      open_q[i] = (miss_q[i] == `MISS_LIMIT);
    end
  end
  wire logic pok_d = smp_q.in_window && !(|open_q); // R3 R4 R5
  // apb decode
  wire logic setup_w  = psel && !penable;
  wire logic wr_w     = psel && penable && pwrite;
  wire logic hit_ctrl = (paddr == `OFS_CTRL);
  wire logic hit_stat = (paddr == `OFS_STATUS);
  wire logic hit_ist  = (paddr == `OFS_IRQ_STAT);
  wire logic hit_iclr = (paddr == `OFS_IRQ_CLR);
  wire logic hit_ien  = (paddr == `OFS_IRQ_EN);
  wire logic mapped_w = hit_ctrl | hit_stat | hit_ist | hit_iclr | hit_ien;
  wire logic [31:0] status_w = {20'h0, open_q, 3'h0, pok_q, slow_w,
                                fold_level_sel, mode_q};
  wire logic [31:0] rdmux_w =
      hit_ctrl ? ctrl_q :
      hit_stat ? status_w :
      hit_ist  ? {28'h0, irq_stat_q} :
      hit_ien  ? {28'h0, irq_en_q} : 32'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (ce && setup_w) begin
      prdata_q  <= pwrite ? 32'h0 : rdmux_w;
      pslverr_q <= !mapped_w;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q   <= `CTRL_RST;
      irq_en_q <= `IRQ_EN_RST;
    end else if (ce && wr_w) begin
      if (hit_ctrl) begin
        ctrl_q <= pwdata;
      end
      if (hit_ien) begin
        irq_en_q <= pwdata[3:0];
      end
    end
  end

  logic       cb_d1_q, off_d1_q, pok_d1_q;
  logic [3:0] open_d1_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cb_d1_q   <= 1'b0;
      off_d1_q  <= 1'b0;
      pok_d1_q  <= 1'b0;
      open_d1_q <= '0;
      mode_q    <= MODE_RUN;
      pok_q     <= 1'b0;
    end else if (ce) begin
      mode_q    <= mode_d;
      pok_q     <= pok_d;
      cb_d1_q   <= cb_q;
      off_d1_q  <= (mode_q == MODE_OFF);
      pok_d1_q  <= pok_q;
      open_d1_q <= open_q;
    end
  end

  wire logic [3:0] ev_w;
  assign ev_w[`EV_CROWBAR] = cb_q && !cb_d1_q;
  assign ev_w[`EV_DISABLE] = (mode_q == MODE_OFF) && !off_d1_q;
  assign ev_w[`EV_POK_FALL] = pok_d1_q && !pok_q;
  assign ev_w[`EV_OPEN]    = |(open_q & ~open_d1_q);
  wire logic [3:0] clr_w = (wr_w && hit_iclr) ? pwdata[3:0] : 4'h0;

  // a new event in the clear cycle survives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_q <= '0;
    end else if (ce) begin
      irq_stat_q <= (irq_stat_q & ~clr_w) | ev_w;
    end
  end

  assign prdata              = prdata_q;
  assign pready              = 1'b1;
  assign pslverr             = pslverr_q && psel && penable;
  assign phase_drive         = drive_q;
  assign fold_level_sel      = smp_q.below_fold; // R1
  assign osc_running         = run_w;
  assign ref_enable          = 1'b1; // R9
  assign power_ok_output_out = 1'b0;
  assign power_ok_output_oe  = !pok_q; // R3
  assign irq                 = |(irq_stat_q & irq_en_q);

  default clocking cb_clk @(posedge clk); endclocking
  default disable iff (sys_rst || !ce);

  sequence s_cb_rise;
    $rose(cb_q) ##1 ce;
  endsequence
  property p_crowbar;
    s_cb_rise |-> ##1 (phase_drive == 4'h0 || !ce);
  endproperty
  a_crowbar: assert property (p_crowbar) else $error("crowbar drive"); // R6
  property p_release;
    $fell(cb_q) && !sync2_q.comp_low |=> mode_q == MODE_RUN;
  endproperty
  a_release: assert property (p_release) else $error("no resume"); // R7
  sequence s_off;
    mode_q == MODE_OFF ##1 mode_q == MODE_OFF;
  endsequence
  property p_disable;
    s_off |-> $stable(ramp_q) && phase_drive == 4'h0 && ref_enable;
  endproperty
  a_disable: assert property (p_disable) else $error("disable"); // R8 R9
  property p_onehot;
    $onehot0(phase_drive);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two phases"); // R12
  property p_window;
    !smp_q.in_window |=> power_ok_output_oe;
  endproperty
  a_window: assert property (p_window) else $error("pok out"); // R3 R4
  property p_open;
    (|open_q) |=> power_ok_output_oe;
  endproperty
  a_open: assert property (p_open) else $error("open phase"); // R5
  // reload is chosen from the sample held before the tick
  property p_rate;
    osc_tick |=> ramp_q == ($past(smp_q.at_zero) ? SLOW_LOAD : NORM_LOAD);
  endproperty
  a_rate: assert property (p_rate) else $error("osc rate"); // R2 R10
  property p_start;
    go_w |=> $onehot(phase_drive & $past(ph_mask));
  endproperty
  a_start: assert property (p_start) else $error("no phase"); // R11
  property p_sample;
    !samp_tick |=> $stable(smp_q);
  endproperty
  a_sample: assert property (p_sample) else $error("sample"); // R13
  property p_fold;
    samp_tick && sync2_q.below_fold |=> fold_level_sel;
  endproperty
  a_fold: assert property (p_fold) else $error("foldback"); // R1
endmodule
`default_nettype wire

/* inc/mps_params.svh */
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH
`define CLK_HZ        40000000
`define OSC_HZ        800000
`define SLOW_FACTOR   5
`define MISS_LIMIT    2'd3
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_IRQ_STAT  8'h08
`define OFS_IRQ_CLR   8'h0c
`define OFS_IRQ_EN    8'h10
`define CTRL_EN_BIT   0
`define CTRL_MASK_LSB 4
`define CTRL_RST      32'h0000_00f1
`define IRQ_EN_RST    4'h0
`define EV_CROWBAR    0
`define EV_DISABLE    1
`define EV_POK_FALL   2
`define EV_OPEN       3
`endif

/* inc/mps_pkg.sv */
package mps_pkg;
  typedef enum logic [1:0] {MODE_RUN, MODE_CROWBAR, MODE_OFF} mode_e;
  typedef struct packed {
    logic below_fold;
    logic at_zero;
    logic in_window;
    logic above_trip;
    logic below_release;
    logic comp_low;
    logic cur_trip;
    logic cur_present;
  } cmp_s;
endpackage

/* tb/drv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module drv_model (
  input  wire logic       clk,
  input  wire logic [3:0] phase_drive,
  input  wire logic [3:0] open_mask,
  output logic            cur_trip,
  output logic            cur_present
);
  logic [3:0] live;
  logic [3:0] on_cnt_q = 4'h0;
  // an open phase carries no current, so its trip never comes
  assign live = phase_drive & ~open_mask;
  initial cur_trip = 1'b0;
  initial cur_present = 1'b0;
  always @(posedge clk) begin
    cur_present <= |live;
    if (live == 4'h0) begin
      on_cnt_q <= 4'h0;
    end else if (on_cnt_q != 4'hf) begin
      on_cnt_q <= on_cnt_q + 4'h1;
    end
    cur_trip <= (on_cnt_q >= 4'h5);
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mps_pkg::*;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic        trip, pres, fold, osc, refe, pok_o, pok_oe, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pd, om, p;
  logic [5:0]  lv;
  cmp_s        cin;
  int          n_fail, tests_run, cyc, t0, t1;
  assign cin = {lv, trip, pres};
  multiphase_protection_supervisor u_dut (.clk(clk), .sys_rst(sys_rst),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_in(cin), .phase_drive(pd),
    .fold_level_sel(fold), .osc_running(osc), .ref_enable(refe),
    .power_ok_output_out(pok_o), .power_ok_output_oe(pok_oe), .irq(irq));
  drv_model u_drv (.clk(clk), .phase_drive(pd), .open_mask(om),
    .cur_trip(trip), .cur_present(pres));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) begin
    if (!sys_rst) begin
      chk("one_hot", 32'($countones(pd)), 32'(pd != 4'h0));
    end
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait for a phase drive to rise out of all-low
  task automatic rise(output logic [3:0] ph, output int t);
    logic [3:0] last;
    int n;
    n = 0;
    do begin
      last = pd;
      @(posedge clk);
      n++;
    end while (!(last === 4'h0 && pd !== 4'h0) && n < 600);
    if (n >= 600) begin
      n_fail++;
      stop_test();
    end
    ph = pd;
    t = cyc;
  endtask
  task automatic t_reset;
    chk("drive", 32'(pd), 0);
    chk("pok_oe", 32'(pok_oe), 1);
    chk("pok_out", 32'(pok_o), 0);
    apb(0, 8'h00, 0);
    chk("ctrl", rd, 32'h0000_00f1);
    apb(0, 8'h10, 0);
    chk("irq_en", rd, 0);
    apb(1, 8'h40, 32'hffff_ffff);
    chk("unmapped_err", 32'(err), 1);
    chk("pready", 32'(pready), 1);
    $display("done reset");
  endtask
  task automatic t_rotate;
    logic [3:0] e;
    e = 4'h1;
    repeat (4) begin
      rise(p, t1);
      chk("phase", 32'(p), 32'(e));
      if (e == 4'h1) t0 = t1;
      e = {e[2:0], e[3]};
    end
    rise(p, t1);
    chk("phase_period", 32'(t1 - t0), 200);
    chk("pok_oe_ok", 32'(pok_oe), 0);
    apb(1, 8'h00, 32'h0000_0051);
    rise(p, t1);
    chk("mask_skip", 32'(p), 32'h4);
    rise(p, t1);
    chk("mask_wrap", 32'(p), 32'h1);
    apb(1, 8'h00, 32'h0000_00f1);
    $display("done rotate");
  endtask
  task automatic t_faults;
    lv[3] <= 1'b0;
    repeat (120) @(posedge clk);
    chk("pok_oe_out", 32'(pok_oe), 1);
    lv[3] <= 1'b1;
    om <= 4'h2;
    repeat (1000) @(posedge clk);
    chk("pok_oe_open", 32'(pok_oe), 1);
    lv[5] <= 1'b1;
    repeat (120) @(posedge clk);
    chk("fold", 32'(fold), 1);
    om <= 4'h0;
    lv[5] <= 1'b0;
    lv[4] <= 1'b1;
    // let one tick take the zero sample so both rises are slow ones
    repeat (60) @(posedge clk);
    rise(p, t0);
    rise(p, t1);
    chk("slow_tick", 32'(t1 - t0), 250);
    lv[4] <= 1'b0;
    repeat (120) @(posedge clk);
    chk("fold_off", 32'(fold), 0);
    $display("done faults");
  endtask
  task automatic t_crowbar;
    logic [3:0] seen;
    apb(1, 8'h10, 32'h0000_0003);
    lv[2] <= 1'b1;
    lv[1] <= 1'b0;
    // a slow tick may still be pending, so wait past it
    repeat (400) @(posedge clk);
    seen = 4'h0;
    repeat (300) begin
      @(posedge clk);
      seen = seen | pd;
    end
    chk("crowbar_drive", 32'(seen), 0);
    chk("irq_on", 32'(irq), 1);
    apb(0, 8'h08, 0);
    chk("stat_crowbar", rd & 32'h1, 1);
    lv[2] <= 1'b0;
    lv[1] <= 1'b1;
    rise(p, t0);
    apb(1, 8'h0c, 32'h0000_0001);
    @(posedge clk);
    chk("irq_clr", 32'(irq), 0);
    lv[0] <= 1'b1;
    repeat (8) @(posedge clk);
    chk("osc_off", 32'(osc), 0);
    chk("drive_off", 32'(pd), 0);
    chk("ref_on", 32'(refe), 1);
    chk("irq_dis", 32'(irq), 1);
    lv[0] <= 1'b0;
    rise(p, t0);
    chk("osc_on", 32'(osc), 1);
    $display("done crowbar_disable");
  endtask
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    om = 4'h0;
    lv = 6'b001010;
    n_fail = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rotate();
    t_faults();
    t_crowbar();
    stop_test();
  end
endmodule
`default_nettype wire
